// ===== hw/tcwm_pkg.sv
// Package for the 8-bit timer compare and waveform block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package tcwm_pkg;
   localparam logic [7:0] TCWM_ADDR_CTRL  = 8'h00;
   localparam logic [7:0] TCWM_ADDR_COUNT = 8'h04;
   localparam logic [7:0] TCWM_ADDR_CMP   = 8'h08;
   localparam logic [7:0] TCWM_ADDR_FLAGS = 8'h0c;
   localparam logic [7:0] TCWM_ADDR_PORT  = 8'h10;
   localparam int TCWM_CTRL_WAVE_LSB  = 0;
   localparam int TCWM_CTRL_COM_LSB   = 2;
   localparam int TCWM_CTRL_FORCE_BIT = 4;
   localparam int TCWM_FLAG_OVF_BIT   = 0;
   localparam int TCWM_FLAG_CMP_BIT   = 1;
   localparam int TCWM_PORT_DATA_BIT  = 0;
   localparam int TCWM_PORT_DIR_BIT   = 1;
   localparam int TCWM_PORT_STATE_BIT = 2;
   localparam logic [7:0] TCWM_BOTTOM = 8'h00;
   localparam logic [7:0] TCWM_MAX    = 8'hff;
   localparam logic [7:0] TCWM_COUNT_RST = 8'h00;
   localparam logic [7:0] TCWM_CMP_RST   = 8'h00;
   localparam logic       TCWM_STATE_RST = 1'b0;

   typedef enum logic [1:0] {
      TCWM_WAVE_NORMAL = 2'h0,
      TCWM_WAVE_PHASE  = 2'h1,
      TCWM_WAVE_CLEAR  = 2'h2,
      TCWM_WAVE_FAST   = 2'h3
   } tcwm_wave_e;

   typedef enum logic [1:0] {
      TCWM_COM_OFF    = 2'h0,
      TCWM_COM_TOGGLE = 2'h1,
      TCWM_COM_CLEAR  = 2'h2,
      TCWM_COM_SET    = 2'h3
   } tcwm_com_e;

   typedef struct packed {
      tcwm_com_e  compare_output_mode;
      tcwm_wave_e waveform_mode;
   } tcwm_ctrl_s;
endpackage

// ===== hw/tcwm_timer.sv
// Compare output and waveform logic of an 8-bit timer with APB registers.
// Assumes a one-cycle timer_tick pulse from an outside prescaler.
`timescale 1ns/10ps
module tcwm_timer
   import tcwm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        timer_tick,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             pin_out,
   output logic             pin_oe
);
   tcwm_ctrl_s  ctrl_r;
   logic [7:0]  counter_value_r;
   logic [7:0]  compare_value_r;
   logic [7:0]  compare_buf_r;
   logic        overflow_flag_r;
   logic        compare_flag_r;
   logic        compare_output_state_r;
   logic        port_data_r;
   logic        compare_pin_direction_bit_r;
   logic        match_pend_r;
   logic        block_r;
   logic [7:0]  counter_nxt;
   logic        state_nxt;
   logic        wr;
   logic        rd;
   logic        is_pwm;
   logic        match;
   logic        force_compare_strobe;
   logic        ovf_set;
   logic        tick;
   logic        state_live;

   function automatic logic wave_is_pwm(input tcwm_wave_e m);
      return m[0];
   endfunction

   function automatic logic [31:0] reg_word(input logic [7:0] a,
                                            input logic [31:0] d);
      return (paddr == a) ? d : 32'h0;
   endfunction

   assign wr      = psel & penable & pwrite & clk_en;
   assign rd      = psel & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable &
                    (paddr > TCWM_ADDR_PORT || paddr[1:0] != 2'h0);
   assign tick    = timer_tick & clk_en;
   assign is_pwm  = wave_is_pwm(ctrl_r.waveform_mode);
   assign match   = (counter_value_r == compare_value_r) & ~block_r;
   assign force_compare_strobe = wr & (paddr == TCWM_ADDR_CTRL) &
                                 pwdata[TCWM_CTRL_FORCE_BIT] & ~is_pwm;
   // The pin may only follow a state change that is really taken.
   assign state_live = (tick || force_compare_strobe) ? state_nxt :
                       compare_output_state_r;

   always_comb begin
      prdata = 32'h0;
      if (rd) begin
         prdata = reg_word(TCWM_ADDR_CTRL, {28'h0,
                  ctrl_r.compare_output_mode, ctrl_r.waveform_mode})
                | reg_word(TCWM_ADDR_COUNT, {24'h0, counter_value_r})
                | reg_word(TCWM_ADDR_CMP, {24'h0, is_pwm ?
                           compare_buf_r : compare_value_r})
                | reg_word(TCWM_ADDR_FLAGS, {30'h0, compare_flag_r,
                           overflow_flag_r})
                | reg_word(TCWM_ADDR_PORT, {29'h0,
                           compare_output_state_r,
                           compare_pin_direction_bit_r, port_data_r});
      end
   end

   // Counting sequence is chosen by the waveform mode alone.
   always_comb begin
      counter_nxt = counter_value_r + 8'h01;
      ovf_set     = 1'b0;
      unique case (ctrl_r.waveform_mode)
         TCWM_WAVE_NORMAL: ovf_set = counter_value_r == TCWM_MAX;
         TCWM_WAVE_CLEAR: begin
            if (counter_value_r == compare_value_r) begin
               counter_nxt = TCWM_BOTTOM;
            end
            ovf_set = counter_value_r == TCWM_MAX;
         end
         TCWM_WAVE_FAST:   ovf_set = counter_value_r == TCWM_MAX;
         TCWM_WAVE_PHASE:  ovf_set = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r                      <= '0;
         port_data_r                 <= 1'b0;
         compare_pin_direction_bit_r <= 1'b0;
      end else if (wr) begin
         if (paddr == TCWM_ADDR_CTRL) begin
            ctrl_r <= tcwm_ctrl_s'(pwdata[3:0]);
         end
         if (paddr == TCWM_ADDR_PORT) begin
            port_data_r                 <= pwdata[TCWM_PORT_DATA_BIT];
            compare_pin_direction_bit_r <= pwdata[TCWM_PORT_DIR_BIT];
         end
      end
   end

   // A software write wins over counting and blocks the next match.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value_r <= TCWM_COUNT_RST;
         block_r         <= 1'b0;
      end else if (clk_en) begin
         if (wr && paddr == TCWM_ADDR_COUNT) begin
            counter_value_r <= pwdata[7:0];
            block_r         <= 1'b1;
         end else if (tick) begin
            counter_value_r <= counter_nxt;
            block_r         <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_value_r <= TCWM_CMP_RST;
         compare_buf_r   <= TCWM_CMP_RST;
      end else if (clk_en) begin
         if (wr && paddr == TCWM_ADDR_CMP) begin
            compare_buf_r <= pwdata[7:0];
            if (!is_pwm) begin
               compare_value_r <= pwdata[7:0];
            end
         end
         if (is_pwm && tick && counter_value_r == TCWM_MAX) begin
            compare_value_r <= compare_buf_r;
         end
      end
   end

   // Flags: hardware set wins over a write-one clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_r <= 1'b0;
         compare_flag_r  <= 1'b0;
         match_pend_r    <= 1'b0;
      end else if (clk_en) begin
         if (tick) begin
            match_pend_r <= match;
         end
         if (tick && ovf_set) begin
            overflow_flag_r <= 1'b1;
         end else if (wr && paddr == TCWM_ADDR_FLAGS &&
                      pwdata[TCWM_FLAG_OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
         end
         if (tick && match) begin
            compare_flag_r <= 1'b1;
         end else if (wr && paddr == TCWM_ADDR_FLAGS &&
                      pwdata[TCWM_FLAG_CMP_BIT]) begin
            compare_flag_r <= 1'b0;
         end
      end
   end

   always_comb begin
      state_nxt = compare_output_state_r;
      if (is_pwm) begin
         if (ctrl_r.waveform_mode == TCWM_WAVE_FAST) begin
            // Match has priority so OCR=FF gives a steady level in the clear and set modes; toggle still inverts at each match.
            if (match) begin
               if (ctrl_r.compare_output_mode == TCWM_COM_CLEAR) begin
                  state_nxt = 1'b0;
               end else if (ctrl_r.compare_output_mode == TCWM_COM_SET) begin
                  state_nxt = 1'b1;
               end else if (ctrl_r.compare_output_mode == TCWM_COM_TOGGLE)
               begin
                  state_nxt = ~compare_output_state_r;
               end
            end else if (counter_value_r == TCWM_MAX) begin
               if (ctrl_r.compare_output_mode == TCWM_COM_CLEAR) begin
                  state_nxt = 1'b1;
               end else if (ctrl_r.compare_output_mode == TCWM_COM_SET) begin
                  state_nxt = 1'b0;
               end
            end
         end
      end else if (match || force_compare_strobe) begin
         unique case (ctrl_r.compare_output_mode)
            TCWM_COM_OFF:    state_nxt = compare_output_state_r;
            TCWM_COM_TOGGLE: state_nxt = ~compare_output_state_r;
            TCWM_COM_CLEAR:  state_nxt = 1'b0;
            TCWM_COM_SET:    state_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_output_state_r <= TCWM_STATE_RST;
      end else if (clk_en && (tick || force_compare_strobe)) begin
         compare_output_state_r <= state_nxt;
      end
   end

   // Port override and direction gating.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else if (clk_en) begin
         pin_out <= (ctrl_r.compare_output_mode != TCWM_COM_OFF) ?
                    state_live : port_data_r;
         pin_oe  <= compare_pin_direction_bit_r;
      end
   end

   a_ovf_normal: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && ctrl_r.waveform_mode == TCWM_WAVE_NORMAL &&
       counter_value_r == TCWM_MAX && !wr)
      |=> (counter_value_r == TCWM_BOTTOM && overflow_flag_r))
      else $error("normal overflow not set at wrap");
   a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && ctrl_r.waveform_mode == TCWM_WAVE_CLEAR && !wr &&
       counter_value_r == compare_value_r)
      |=> counter_value_r == TCWM_BOTTOM)
      else $error("counter not cleared at compare");
   a_cmp_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && match) |=> compare_flag_r)
      else $error("compare flag not set after match");
   a_reset_state: assert property (@(posedge pclk)
      $rose(presetn) |-> !compare_output_state_r)
      else $error("output state not zero after reset");
   a_force_noflag: assert property (@(posedge pclk) disable iff (!presetn)
      (force_compare_strobe && !tick && !compare_flag_r)
      |=> !compare_flag_r)
      else $error("force set the compare flag");
   a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !compare_pin_direction_bit_r) |=> !pin_oe)
      else $error("pin driven while input");
   a_toggle_act: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && match && !is_pwm && !force_compare_strobe &&
       ctrl_r.compare_output_mode == TCWM_COM_TOGGLE)
      |=> compare_output_state_r != $past(compare_output_state_r))
      else $error("toggle mode did not invert");
   a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !is_pwm && ctrl_r.compare_output_mode == TCWM_COM_OFF)
      |=> $stable(compare_output_state_r))
      else $error("state changed with output mode off");
   a_fast_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !wr && ctrl_r.waveform_mode == TCWM_WAVE_FAST &&
       counter_value_r == TCWM_MAX) |=> counter_value_r == TCWM_BOTTOM &&
       overflow_flag_r)
      else $error("fast mode wrap wrong");
   a_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
      (!tick && !wr) |=> $stable(counter_value_r))
      else $error("counter moved without tick");

   // Pin source and register access checks.
   a_pin_override: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r.compare_output_mode != TCWM_COM_OFF)
      |=> pin_out == compare_output_state_r)
      else $error("pin does not follow compare state");

   a_pin_port: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ctrl_r.compare_output_mode == TCWM_COM_OFF)
      |=> pin_out == $past(port_data_r))
      else $error("pin does not follow port data");

   a_count_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == TCWM_ADDR_COUNT)
      |=> counter_value_r == $past(pwdata[7:0]))
      else $error("counter write lost");

   a_direct_cmp: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == TCWM_ADDR_CMP && !is_pwm)
      |=> compare_value_r == $past(pwdata[7:0]))
      else $error("compare write not direct");

   a_pwm_reload: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && is_pwm && counter_value_r == TCWM_MAX)
      |=> compare_value_r == $past(compare_buf_r))
      else $error("buffered compare not loaded at top");

   // Counting and flag checks.
   a_normal_inc: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !wr && ctrl_r.waveform_mode == TCWM_WAVE_NORMAL)
      |=> counter_value_r == $past(counter_value_r) + 8'h01)
      else $error("normal mode did not increment");

   a_ctc_ovf: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && ctrl_r.waveform_mode == TCWM_WAVE_CLEAR &&
       counter_value_r == TCWM_MAX) |=> overflow_flag_r)
      else $error("clear mode overflow not set");

   a_ctc_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && match && ctrl_r.waveform_mode == TCWM_WAVE_CLEAR)
      |=> compare_flag_r)
      else $error("clear mode compare flag not set");

   a_flag_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!tick && !wr)
      |=> $stable(overflow_flag_r) && $stable(compare_flag_r))
      else $error("flag moved without tick");

   a_force_count: assert property (
      @(posedge pclk) disable iff (!presetn)
      (force_compare_strobe && !tick) |=> $stable(counter_value_r))
      else $error("force moved the counter");

   // Output state actions.
   a_force_act: assert property (
      @(posedge pclk) disable iff (!presetn)
      (force_compare_strobe && ctrl_r.compare_output_mode == TCWM_COM_SET)
      |=> compare_output_state_r)
      else $error("force did not act at once");

   a_clear_act: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && match && !is_pwm &&
       ctrl_r.compare_output_mode == TCWM_COM_CLEAR)
      |=> !compare_output_state_r)
      else $error("clear action not taken");

   a_set_act: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && match && !is_pwm &&
       ctrl_r.compare_output_mode == TCWM_COM_SET)
      |=> compare_output_state_r)
      else $error("set action not taken");

   a_fast_match: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && match && ctrl_r.waveform_mode == TCWM_WAVE_FAST &&
       ctrl_r.compare_output_mode == TCWM_COM_CLEAR)
      |=> !compare_output_state_r)
      else $error("fast mode match did not clear");

   a_fast_bottom: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !match && ctrl_r.waveform_mode == TCWM_WAVE_FAST &&
       counter_value_r == TCWM_MAX &&
       ctrl_r.compare_output_mode == TCWM_COM_CLEAR)
      |=> compare_output_state_r)
      else $error("fast mode bottom did not set");

   a_fast_steady: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tick && !block_r && ctrl_r.waveform_mode == TCWM_WAVE_FAST &&
       compare_value_r == TCWM_MAX && counter_value_r == TCWM_MAX &&
       ctrl_r.compare_output_mode == TCWM_COM_SET)
      |=> compare_output_state_r)
      else $error("fast mode top level not steady");
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the timer compare and waveform block.
// Assumes the zero-wait APB slave and the pin load model beside it.
`timescale 1ns/10ps
module tb_top;
   import tcwm_pkg::*;
   logic        pclk, presetn, clk_en, timer_tick;
   logic        psel, penable, pwrite;
   logic [7:0]  paddr, rnd;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, pin_out, pin_oe, pad_level;
   int          n_fail, n_compared;
   logic [32:0] exp_q[$];
   logic [32:0] note;
   tcwm_com_e   coms[5] = '{TCWM_COM_TOGGLE, TCWM_COM_CLEAR,
                            TCWM_COM_SET, TCWM_COM_OFF, TCWM_COM_TOGGLE};
   logic [0:4]  sts = 5'b10110;

   tcwm_timer u_tcwm_timer (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .timer_tick(timer_tick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_out(pin_out), .pin_oe(pin_oe));
   tcwm_pin_load u_tcwm_pin_load (.pin_out(pin_out), .pin_oe(pin_oe),
      .pad_level(pad_level));

   always #50 pclk = ~pclk;

   task automatic check(string what, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] d, logic e = 1'b0);
      exp_q.push_back({e, d});
      wr(1'b0, a, 32'h0);
   endtask

   task automatic tick(int n);
      repeat (n) begin
         @(posedge pclk);
         timer_tick <= 1'b1;
         @(posedge pclk);
         timer_tick <= 1'b0;
      end
   endtask

   task automatic pin(logic e);
      @(negedge pclk);
      check("pad_level", {31'h0, e}, {31'h0, pad_level});
   endtask

   // Read results are compared where they appear, against queued notes.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("CHECK FAILED read note expected none seen %h", prdata);
         end else begin
            note = exp_q.pop_front();
            check("prdata", note[31:0], prdata);
            check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
         end
      end
   end

   initial begin
      #2_000_000;
      n_fail++;
      wrap_up();
   end

   initial begin
      pclk = 0;
      presetn = 0;
      clk_en = 1;
      timer_tick = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(90));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 'h10; a += 4) rd(a[7:0], 32'h0);
      rd(8'h14, 32'h0, 1'b1);
      @(negedge pclk);
      check("pin_oe", 32'h0, {31'h0, pin_oe});
      $display("test reset done");

      rnd = 8'($urandom());
      wr(1'b1, TCWM_ADDR_COUNT, {24'h0, rnd});
      rd(TCWM_ADDR_COUNT, {24'h0, rnd});
      wr(1'b1, TCWM_ADDR_COUNT, 32'hfe);
      tick(1);
      rd(TCWM_ADDR_COUNT, 32'hff);
      rd(TCWM_ADDR_FLAGS, 32'h0);
      tick(1);
      rd(TCWM_ADDR_COUNT, 32'h0);
      rd(TCWM_ADDR_FLAGS, 32'h1);
      clk_en <= 1'b0;
      tick(2);
      clk_en <= 1'b1;
      rd(TCWM_ADDR_COUNT, 32'h0);
      $display("test normal done");

      wr(1'b1, TCWM_ADDR_PORT, 32'h2);
      wr(1'b1, TCWM_ADDR_CMP, 32'h3);
      foreach (coms[i]) begin
         wr(1'b1, TCWM_ADDR_CTRL, {28'h0, coms[i], 2'h2});
         wr(1'b1, TCWM_ADDR_FLAGS, 32'h3);
         tick(4);
         rd(TCWM_ADDR_COUNT, 32'h0);
         rd(TCWM_ADDR_FLAGS, 32'h2);
         rd(TCWM_ADDR_PORT, {29'h0, sts[i], 2'h2});
         pin(coms[i] != TCWM_COM_OFF ? sts[i] : 1'b0);
      end
      $display("test match actions done");

      wr(1'b1, TCWM_ADDR_PORT, 32'h0);
      wr(1'b1, TCWM_ADDR_FLAGS, 32'h3);
      wr(1'b1, TCWM_ADDR_CTRL, 32'h14);
      rd(TCWM_ADDR_PORT, 32'h4);
      rd(TCWM_ADDR_FLAGS, 32'h0);
      rd(TCWM_ADDR_COUNT, 32'h0);
      pin(1'b1);
      $display("test force done");

      wr(1'b1, TCWM_ADDR_CTRL, 32'h2);
      wr(1'b1, TCWM_ADDR_COUNT, 32'h10);
      wr(1'b1, TCWM_ADDR_CMP, 32'h5);
      wr(1'b1, TCWM_ADDR_FLAGS, 32'h3);
      tick(240);
      rd(TCWM_ADDR_FLAGS, 32'h1);
      tick(6);
      rd(TCWM_ADDR_COUNT, 32'h0);
      rd(TCWM_ADDR_FLAGS, 32'h3);
      $display("test missed match done");

      wr(1'b1, TCWM_ADDR_CTRL, 32'hb);
      wr(1'b1, TCWM_ADDR_PORT, 32'h2);
      wr(1'b1, TCWM_ADDR_CMP, 32'h40);
      wr(1'b1, TCWM_ADDR_COUNT, 32'hfe);
      wr(1'b1, TCWM_ADDR_FLAGS, 32'h3);
      tick(2);
      rd(TCWM_ADDR_COUNT, 32'h0);
      rd(TCWM_ADDR_FLAGS, 32'h1);
      tick(32'h20);
      wr(1'b1, TCWM_ADDR_CMP, 32'h30);
      rd(TCWM_ADDR_CMP, 32'h30);
      tick(32'h12);
      rd(TCWM_ADDR_PORT, 32'h6);
      tick(32'h0f);
      rd(TCWM_ADDR_PORT, 32'h2);
      pin(1'b0);
      tick(32'hbf);
      rd(TCWM_ADDR_COUNT, 32'h0);
      rd(TCWM_ADDR_PORT, 32'h6);
      wr(1'b1, TCWM_ADDR_CTRL, 32'hf);
      tick(32'h100);
      rd(TCWM_ADDR_PORT, 32'h2);
      tick(32'h31);
      rd(TCWM_ADDR_PORT, 32'h6);
      wr(1'b1, TCWM_ADDR_CMP, 32'hff);
      tick(32'h1cf);
      rd(TCWM_ADDR_PORT, 32'h6);
      tick(32'h80);
      rd(TCWM_ADDR_PORT, 32'h6);
      tick(32'h80);
      rd(TCWM_ADDR_PORT, 32'h6);
      pin(1'b1);
      $display("test fast pwm done");
      wrap_up();
   end
endmodule

// ===== test/tcwm_pin_load.sv
// Load on the compare pin: a pull-up that the pad falls back to.
// Assumes pin_oe high means the block drives pin_out onto the pad.
`timescale 1ns/10ps
module tcwm_pin_load (
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pad_level
);
   // An undriven pad is pulled high, never left at its last value.
   assign pad_level = pin_oe ? pin_out : 1'b1;
endmodule
